// >>> rtl/ccr4_ctrl_reg.sv
// Purpose: Charger control register four with watchdog and detection
// Assumes: Register access port driven by the serial link front end
// Notes: Read data appears one cycle after the read strobe
`include "ccr4_params.svh"
`default_nettype none
module ccr4_ctrl_reg #(
    parameter int unsigned WDT_TICK_CYCLES = `CCR4_WDT_TICK_NS / `CCR4_CLK_PERIOD_NS
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic reg_rst_cmd_in,
    input wire logic [7:0] acc_addr_in,
    input wire logic acc_wr_in,
    input wire logic acc_rd_in,
    input wire logic [7:0] acc_wdata_in,
    output logic [7:0] acc_rdata_out,
    input wire logic wdt_kick_in,
    input wire logic [2:0] wdt_period_sel_in,
    output logic wdt_expired_out,
    input wire logic input2_blocking_fet_pair_in,
    input wire logic input1_blocking_fet_pair_in,
    input wire logic strap_config_pin_in,
    input wire logic vbat_above_min_in,
    input wire logic adc_done_in,
    input wire logic [7:0] adc_result_in,
    output logic input2_gate_drive_on_out,
    output logic input1_gate_drive_on_out,
    output logic switching_freq_sel_out,
    output logic status_pin_off_out,
    output logic sys_short_hiccup_off_out,
    output logic otg_undervolt_hiccup_off_out,
    output logic input_overcurrent_prot_on_out,
    output logic force_input_limit_detect_out,
    output logic switching_stop_out,
    output logic adc_measure_out,
    output logic input_voltage_limit_wr_out,
    output logic [7:0] input_voltage_limit_out
);
    ccr4_det_if det_link ();

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [1:0] load_cnt_q;
    logic load_now;
    logic in2_ok_q;
    logic in1_ok_q;
    logic in2_q;
    logic in1_q;
    logic freq_q;
    logic stat_off_q;
    logic short_off_q;
    logic uvp_off_q;
    logic force_q;
    logic ocp_q;
    logic [7:0] rdata_q;
    logic wr_hit;
    logic rd_hit;
    logic force_set;
    logic [17:0] tick_cnt_q;
    logic [17:0] ms_cnt_q;
    logic wdt_exp_q;
    logic wdt_restart;
    logic [17:0] wdt_limit;
    logic [7:0] reg_view;

    // Address decode shared by the read and write paths
    function automatic logic addr_hit(input logic [7:0] addr);
        addr_hit = (addr == `CCR4_ADDR);
    endfunction : addr_hit

    // Watchdog period table in ms ticks; zero means disabled
    function automatic logic [17:0] wdt_ms(input logic [2:0] sel);
        unique case (sel)
            3'h0: wdt_ms = 18'h00000;
            3'h1: wdt_ms = `CCR4_WDT_MS_0P5;
            3'h2: wdt_ms = `CCR4_WDT_MS_1;
            3'h3: wdt_ms = `CCR4_WDT_MS_2;
            3'h4: wdt_ms = `CCR4_WDT_MS_20;
            3'h5: wdt_ms = `CCR4_WDT_MS_40;
            3'h6: wdt_ms = `CCR4_WDT_MS_80;
            3'h7: wdt_ms = `CCR4_WDT_MS_160;
        endcase
    endfunction : wdt_ms

    assign wr_hit = acc_wr_in && addr_hit(acc_addr_in);
    assign rd_hit = acc_rd_in && addr_hit(acc_addr_in);

    // Pin synchronisers: strap, two presence pins, battery comparator
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end
        else
        begin
            pin_s1_q <= {vbat_above_min_in, strap_config_pin_in,
                         input1_blocking_fet_pair_in, input2_blocking_fet_pair_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Power-on capture waits for the synchronisers to fill after release
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            load_cnt_q <= 2'h0;
        else if (load_cnt_q != `CCR4_STRAP_LOAD_CYC)
            load_cnt_q <= load_cnt_q + 2'h1;
    end
    assign load_now = (load_cnt_q == `CCR4_STRAP_LOAD_CYC - 2'h1);

    // Presence is judged once at power-on; absence locks the gate bit
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            in2_ok_q <= 1'h0;
            in1_ok_q <= 1'h0;
        end
        else if (load_now)
        begin
            in2_ok_q <= pin_s2_q[0];
            in1_ok_q <= pin_s2_q[1];
        end
    end

    // Gate drive bits; not touched by register reset or watchdog
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            in2_q <= `CCR4_RST_GATE;
            in1_q <= `CCR4_RST_GATE;
        end
        else
        begin
            if (!in2_ok_q)
                in2_q <= 1'h0;
            else if (wr_hit)
                in2_q <= acc_wdata_in[`CCR4_BIT_IN2_GATE];
            if (!in1_ok_q)
                in1_q <= 1'h0;
            else if (wr_hit)
                in1_q <= acc_wdata_in[`CCR4_BIT_IN1_GATE];
        end
    end

    // Frequency select loads from strap; a write made before load is overridden
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            freq_q <= 1'h0;
        else if (load_now)
            freq_q <= pin_s2_q[2];
        else if (wr_hit)
            freq_q <= acc_wdata_in[`CCR4_BIT_FREQ];
    end

    // Status pin disable also falls back on watchdog expiry
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || reg_rst_cmd_in || wdt_exp_q)
            stat_off_q <= `CCR4_RST_STAT_OFF;
        else if (wr_hit)
            stat_off_q <= acc_wdata_in[`CCR4_BIT_STAT_OFF];
    end

    // Protection fields survive the watchdog
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || reg_rst_cmd_in)
        begin
            short_off_q <= `CCR4_RST_SHORT_OFF;
            uvp_off_q <= `CCR4_RST_UVP_OFF;
            ocp_q <= `CCR4_RST_OCP_ON;
        end
        else if (wr_hit)
        begin
            short_off_q <= acc_wdata_in[`CCR4_BIT_SHORT_OFF];
            uvp_off_q <= acc_wdata_in[`CCR4_BIT_UVP_OFF];
            ocp_q <= acc_wdata_in[`CCR4_BIT_OCP_ON];
        end
    end

    // Detection request: set wins over the completion clear
    assign force_set = wr_hit && acc_wdata_in[`CCR4_BIT_FORCE_DET] && pin_s2_q[3];
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || reg_rst_cmd_in)
            force_q <= `CCR4_RST_FORCE_DET;
        else if (force_set)
            force_q <= 1'h1;
        else if (det_link.done)
            force_q <= 1'h0;
    end

    // Read view; locked bits are already zero in their flops
    assign reg_view = {in2_q, in1_q, freq_q, stat_off_q,
                       short_off_q, uvp_off_q, force_q, ocp_q};
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            rdata_q <= 8'h00;
        else if (acc_rd_in)
            rdata_q <= rd_hit ? reg_view : 8'h00;
    end

    // Watchdog: any access or kick restarts; selection zero disables
    assign wdt_limit = wdt_ms(wdt_period_sel_in);
    assign wdt_restart = wdt_kick_in || acc_wr_in || acc_rd_in || (wdt_limit == 18'h00000);
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in || wdt_restart)
        begin
            tick_cnt_q <= 18'h00000;
            ms_cnt_q <= 18'h00000;
            wdt_exp_q <= 1'h0;
        end
        else if (tick_cnt_q == 18'(WDT_TICK_CYCLES - 1))
        begin
            tick_cnt_q <= 18'h00000;
            if (ms_cnt_q + 18'h00001 >= wdt_limit)
            begin
                ms_cnt_q <= 18'h00000;
                wdt_exp_q <= 1'h1;
            end
            else
            begin
                ms_cnt_q <= ms_cnt_q + 18'h00001;
                wdt_exp_q <= 1'h0;
            end
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 18'h00001;
            wdt_exp_q <= 1'h0;
        end
    end

    // Sequencer runs the forced detection
    assign det_link.req = force_q;
    ccr4_vlim_detect u_detect (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .det(det_link),
        .adc_done_in(adc_done_in),
        .adc_result_in(adc_result_in),
        .switching_stop_out(switching_stop_out),
        .adc_measure_out(adc_measure_out),
        .input_voltage_limit_wr_out(input_voltage_limit_wr_out),
        .input_voltage_limit_out(input_voltage_limit_out)
    );

    // Field outputs straight from their flops
    assign acc_rdata_out = rdata_q;
    assign wdt_expired_out = wdt_exp_q;
    assign input2_gate_drive_on_out = in2_q;
    assign input1_gate_drive_on_out = in1_q;
    assign switching_freq_sel_out = freq_q;
    assign status_pin_off_out = stat_off_q;
    assign sys_short_hiccup_off_out = short_off_q;
    assign otg_undervolt_hiccup_off_out = uvp_off_q;
    assign input_overcurrent_prot_on_out = ocp_q;
    assign force_input_limit_detect_out = force_q;

    a_read_view:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        rd_hit |=> acc_rdata_out == $past(reg_view))
    else $error("read data does not match register");

    a_lock_in2:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !in2_ok_q |-> !input2_gate_drive_on_out)
    else $error("second gate drive on while locked");

    a_lock_in1:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        !in1_ok_q && wr_hit |=> !input1_gate_drive_on_out)
    else $error("locked first gate drive accepted write");

    a_strap_load:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        load_now |=> switching_freq_sel_out == $past(pin_s2_q[2]))
    else $error("frequency select not loaded from strap");

    a_stat_wdt:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        wdt_exp_q |=> !status_pin_off_out)
    else $error("status disable survived watchdog");

    a_short_keep:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        wdt_exp_q && !reg_rst_cmd_in && !wr_hit |=> $stable(sys_short_hiccup_off_out))
    else $error("short hiccup field changed by watchdog");

    a_uvp_regrst:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        reg_rst_cmd_in |=> !otg_undervolt_hiccup_off_out && input_overcurrent_prot_on_out)
    else $error("register reset did not restore protections");

    a_force_gate:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        wr_hit && !pin_s2_q[3] && !force_q |=> !force_input_limit_detect_out)
    else $error("detection request set below minimum system voltage");

    a_force_clear:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        det_link.done && !force_set |=> !force_input_limit_detect_out)
    else $error("detection request not cleared on completion");

    a_force_start:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        force_q && !det_link.busy && !reg_rst_cmd_in |=> ##1 switching_stop_out)
    else $error("detection request did not stop switching");
endmodule : ccr4_ctrl_reg
`default_nettype wire

// >>> rtl/ccr4_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by bare name from rtl files
// Notes: Definitions only
`ifndef CCR4_PARAMS_SVH
`define CCR4_PARAMS_SVH

// Register location
`define CCR4_ADDR 8'h13

// Field positions
`define CCR4_BIT_IN2_GATE 7
`define CCR4_BIT_IN1_GATE 6
`define CCR4_BIT_FREQ 5
`define CCR4_BIT_STAT_OFF 4
`define CCR4_BIT_SHORT_OFF 3
`define CCR4_BIT_UVP_OFF 2
`define CCR4_BIT_FORCE_DET 1
`define CCR4_BIT_OCP_ON 0

// Reset values
`define CCR4_RST_GATE 1'h0
`define CCR4_RST_STAT_OFF 1'h0
`define CCR4_RST_SHORT_OFF 1'h0
`define CCR4_RST_UVP_OFF 1'h0
`define CCR4_RST_FORCE_DET 1'h0
`define CCR4_RST_OCP_ON 1'h1

// Timing: clock period and watchdog tick, both in ns
`define CCR4_CLK_PERIOD_NS 4
`define CCR4_WDT_TICK_NS 1000000
// Capture falls on the third edge after release: the synchronisers are
// cleared by reset and need two edges before they hold real pin levels
`define CCR4_STRAP_LOAD_CYC 2'h3

// Watchdog periods in ms ticks
`define CCR4_WDT_MS_0P5 18'h001F4
`define CCR4_WDT_MS_1 18'h003E8
`define CCR4_WDT_MS_2 18'h007D0
`define CCR4_WDT_MS_20 18'h04E20
`define CCR4_WDT_MS_40 18'h09C40
`define CCR4_WDT_MS_80 18'h13880
`define CCR4_WDT_MS_160 18'h27100

`endif

// >>> rtl/ccr4_pkg.sv
// Purpose: Shared types of the charger control register block
// Assumes: Nothing
// Notes: Constants live in ccr4_params.svh
`default_nettype none
package ccr4_pkg;
    typedef enum logic [3:0] {
        CCR4_DET_IDLE = 4'h1,
        CCR4_DET_STOP = 4'h2,
        CCR4_DET_MEAS = 4'h4,
        CCR4_DET_UPD = 4'h8
    } ccr4_det_state_t;
    typedef logic [7:0] ccr4_byte_t;
endpackage : ccr4_pkg
`default_nettype wire

// >>> rtl/ccr4_det_if.sv
// Purpose: Request link between register and detection sequencer
// Assumes: Both ends on clk_sys_in
// Notes: done is a one-cycle pulse
`default_nettype none
interface ccr4_det_if;
    logic req;
    logic busy;
    logic done;
    modport ctrl (output req, input busy, input done);
    modport det (input req, output busy, output done);
endinterface : ccr4_det_if
`default_nettype wire

// >>> rtl/ccr4_vlim_detect.sv
// Purpose: Forced input-voltage-limit detection sequence
// Assumes: ADC result and done pulse come from same-clock logic
// Notes: One idle cycle of stopped switching precedes the measurement
`include "ccr4_params.svh"
`default_nettype none
module ccr4_vlim_detect (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    ccr4_det_if.det det,
    input wire logic adc_done_in,
    input wire logic [7:0] adc_result_in,
    output logic switching_stop_out,
    output logic adc_measure_out,
    output logic input_voltage_limit_wr_out,
    output logic [7:0] input_voltage_limit_out
);
    ccr4_pkg::ccr4_det_state_t state_q;
    ccr4_pkg::ccr4_byte_t limit_q;

    // Sequencer: stop, measure unloaded bus, then update limit
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            state_q <= ccr4_pkg::CCR4_DET_IDLE;
        else
        begin
            unique case (state_q)
                ccr4_pkg::CCR4_DET_IDLE:
                    if (det.req)
                        state_q <= ccr4_pkg::CCR4_DET_STOP;
                ccr4_pkg::CCR4_DET_STOP:
                    state_q <= ccr4_pkg::CCR4_DET_MEAS;
                ccr4_pkg::CCR4_DET_MEAS:
                    if (adc_done_in)
                        state_q <= ccr4_pkg::CCR4_DET_UPD;
                ccr4_pkg::CCR4_DET_UPD:
                    state_q <= ccr4_pkg::CCR4_DET_IDLE;
                default:
                    state_q <= ccr4_pkg::CCR4_DET_IDLE;
            endcase
        end
    end

    // Result capture; held until the next detection
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            limit_q <= 8'h00;
        else if (state_q == ccr4_pkg::CCR4_DET_MEAS && adc_done_in)
            limit_q <= adc_result_in;
    end

    // No input current while measuring: converter held off whole sequence
    assign switching_stop_out = (state_q != ccr4_pkg::CCR4_DET_IDLE);
    assign adc_measure_out = (state_q == ccr4_pkg::CCR4_DET_MEAS);
    assign input_voltage_limit_wr_out = (state_q == ccr4_pkg::CCR4_DET_UPD);
    assign input_voltage_limit_out = limit_q;
    assign det.busy = (state_q != ccr4_pkg::CCR4_DET_IDLE);
    assign det.done = (state_q == ccr4_pkg::CCR4_DET_UPD);

    a_meas_stopped:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        adc_measure_out |-> switching_stop_out && $past(switching_stop_out))
    else $error("measurement while converter switching");

    a_limit_update:
    assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        adc_measure_out && adc_done_in |=> input_voltage_limit_wr_out
            && input_voltage_limit_out == $past(adc_result_in))
    else $error("limit not updated from measurement");
endmodule : ccr4_vlim_detect
`default_nettype wire

// >>> tb/test_charger_control_reg_four.sv
// Purpose: Self-checking bench for the charger control register block
// Assumes: Register port, pins and ADC handshake driven on the falling edge
// Notes: Watchdog tick shortened to 4 cycles per ms to keep the run short
`default_nettype none
module test_charger_control_reg_four;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    localparam int LIMIT = 30000;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reg_rst_cmd_in = 1'b0;
    logic [7:0] acc_addr_in = 8'h00;
    logic acc_wr_in = 1'b0;
    logic acc_rd_in = 1'b0;
    logic [7:0] acc_wdata_in = 8'h00;
    logic [7:0] acc_rdata_out;
    logic wdt_kick_in = 1'b0;
    logic [2:0] wdt_period_sel_in = 3'h0;
    logic wdt_expired_out;
    logic pair2 = 1'b0;
    logic pair1 = 1'b1;
    logic strap = 1'b1;
    logic vbat_above_min_in = 1'b0;
    logic adc_done_in = 1'b0;
    logic [7:0] adc_result_in = 8'h00;
    logic [7:0] fld;
    logic sw_stop, adc_meas, lim_wr;
    logic [7:0] lim;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    ccr4_ctrl_reg #(.WDT_TICK_CYCLES(TICK)) ccr4_ctrl_reg_inst (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .reg_rst_cmd_in(reg_rst_cmd_in),
        .acc_addr_in(acc_addr_in),
        .acc_wr_in(acc_wr_in),
        .acc_rd_in(acc_rd_in),
        .acc_wdata_in(acc_wdata_in),
        .acc_rdata_out(acc_rdata_out),
        .wdt_kick_in(wdt_kick_in),
        .wdt_period_sel_in(wdt_period_sel_in),
        .wdt_expired_out(wdt_expired_out),
        .input2_blocking_fet_pair_in(pair2),
        .input1_blocking_fet_pair_in(pair1),
        .strap_config_pin_in(strap),
        .vbat_above_min_in(vbat_above_min_in),
        .adc_done_in(adc_done_in),
        .adc_result_in(adc_result_in),
        .input2_gate_drive_on_out(fld[7]),
        .input1_gate_drive_on_out(fld[6]),
        .switching_freq_sel_out(fld[5]),
        .status_pin_off_out(fld[4]),
        .sys_short_hiccup_off_out(fld[3]),
        .otg_undervolt_hiccup_off_out(fld[2]),
        .force_input_limit_detect_out(fld[1]),
        .input_overcurrent_prot_on_out(fld[0]),
        .switching_stop_out(sw_stop),
        .adc_measure_out(adc_meas),
        .input_voltage_limit_wr_out(lim_wr),
        .input_voltage_limit_out(lim)
    );

    // 250 MHz clock
    always #2 clk_sys_in = ~clk_sys_in;

    // Hang guard: counts as a mismatch, then closes the run
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : ticks

    // Strobe held for exactly one rising edge
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        acc_addr_in = a;
        acc_wdata_in = d;
        acc_wr_in = 1'b1;
        ticks(1);
        acc_wr_in = 1'b0;
        ticks(1);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        acc_addr_in = a;
        acc_rd_in = 1'b1;
        ticks(1);
        acc_rd_in = 1'b0;
        ticks(1);
        d = acc_rdata_out;
    endtask : reg_read

    // Read register and compare both the read data and the field outputs
    task automatic expect_reg(input string what, input logic [7:0] exp);
        logic [7:0] d;
        reg_read(8'h13, d);
        check(what, exp, d);
        check({what, " pins"}, exp, fld);
    endtask : expect_reg

    // Pins stay stable through the reset so the strap capture is clean
    task automatic do_reset();
        sys_rst_in = 1'b1;
        ticks(16);
        sys_rst_in = 1'b0;
        ticks(4);
    endtask : do_reset

    task automatic t_defaults();
        expect_reg("reset value", 8'h21);
    endtask : t_defaults

    // Absent pair locks bit 7; unmapped places read zero and ignore writes
    task automatic t_write_lock();
        logic [7:0] d;
        reg_write(8'h13, 8'hFD);
        expect_reg("write all", 8'h7D);
        reg_write(8'h12, 8'h00);
        expect_reg("unmapped write", 8'h7D);
        reg_read(8'h14, d);
        check("unmapped read", 8'h00, d);
        reg_write(8'h13, 8'h20);
        expect_reg("clear all", 8'h20);
    endtask : t_write_lock

    task automatic t_reg_reset();
        reg_write(8'h13, 8'h5C);
        reg_rst_cmd_in = 1'b1;
        ticks(1);
        reg_rst_cmd_in = 1'b0;
        ticks(1);
        expect_reg("register reset", 8'h41);
    endtask : t_reg_reset

    task automatic t_detect();
        int n;
        reg_write(8'h13, 8'h43);
        expect_reg("force refused", 8'h41);
        vbat_above_min_in = 1'b1;
        ticks(4);
        reg_write(8'h13, 8'h43);
        check("force set", 8'h43, fld);
        n = 0;
        while (adc_meas !== 1'b1 && n < 10)
        begin
            ticks(1);
            n++;
        end
        check("stop while measuring", 8'h01, {7'h00, sw_stop});
        check("measuring", 8'h01, {7'h00, adc_meas});
        ticks(3);
        check("still measuring", 8'h01, {7'h00, adc_meas});
        adc_result_in = 8'hA5;
        adc_done_in = 1'b1;
        ticks(1);
        adc_done_in = 1'b0;
        check("limit write", 8'h01, {7'h00, lim_wr});
        check("limit value", 8'hA5, lim);
        ticks(3);
        check("stop released", 8'h00, {7'h00, sw_stop});
        expect_reg("force cleared", 8'h41);
        vbat_above_min_in = 1'b0;
    endtask : t_detect

    // Kick midway restarts the count; expiry clears bit 4 only
    task automatic t_watchdog();
        int n;
        reg_write(8'h13, 8'h5C);
        wdt_period_sel_in = 3'h1;
        ticks(1000);
        wdt_kick_in = 1'b1;
        ticks(1);
        wdt_kick_in = 1'b0;
        n = 1;
        while (wdt_expired_out !== 1'b1 && n < 2100)
        begin
            ticks(1);
            n++;
        end
        check("expiry early", 8'h01, {7'h00, n >= 500 * TICK - 6});
        check("expiry late", 8'h01, {7'h00, n <= 500 * TICK + 6});
        ticks(1);
        wdt_period_sel_in = 3'h0;
        expect_reg("after expiry", 8'h4C);
        // One-second setting: count runs from the last held-cleared edge
        wdt_period_sel_in = 3'h2;
        n = 0;
        while (wdt_expired_out !== 1'b1 && n < 4100)
        begin
            ticks(1);
            n++;
        end
        wdt_period_sel_in = 3'h0;
        check("one second early", 8'h01, {7'h00, n >= 1000 * TICK - 6});
        check("one second late", 8'h01, {7'h00, n <= 1000 * TICK + 6});
        ticks(2);
    endtask : t_watchdog

    // Second power-on: strap low, only the second pair present
    task automatic t_strap_pairs();
        strap = 1'b0;
        pair2 = 1'b1;
        pair1 = 1'b0;
        do_reset();
        expect_reg("strap low reset", 8'h01);
        reg_write(8'h13, 8'hE1);
        expect_reg("pair one locked", 8'hA1);
        reg_write(8'h13, 8'h00);
        expect_reg("all off", 8'h00);
    endtask : t_strap_pairs

    initial
    begin
        do_reset();
        t_defaults();
        t_write_lock();
        t_reg_reset();
        t_detect();
        t_watchdog();
        t_strap_pairs();
        conclude();
    end
endmodule : test_charger_control_reg_four
`default_nettype wire
